// [design/dss_select.sv]
// Speed arrival, standby interpretation and terminal priority logic with APB registers
`include "dss_regs.svh"

module dss_select (
	// Clock and reset
	input  logic                 pclk,
	input  logic                 presetn,
	// APB slave
	input  logic                 psel,
	input  logic                 penable,
	input  logic                 pwrite,
	input  logic [7:0]           paddr,
	input  logic [31:0]          pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	// Drive state
	input  dss_pkg::dss_freq_t   output_freq,
	input  logic                 panel_run_fwd,
	input  logic                 panel_run_rev,
	// Contact inputs, high while closed to common
	input  logic                 standby_terminal,
	input  logic                 fwd_terminal,
	input  logic                 rev_terminal,
	input  logic                 multi_input_three,
	input  logic                 multi_input_four,
	// Open collector outputs, high while transistor conducts
	output logic                 first_open_collector_output,
	output logic                 second_open_collector_output,
	// Commands to the drive core
	output logic                 gate_enable,
	output logic                 run_fwd,
	output logic                 run_rev,
	output logic                 ramp_stop,
	output logic                 jog_cmd,
	output logic                 inj_brake_cmd,
	output logic                 forced_jog_fwd,
	output logic                 forced_jog_rev
);
	import dss_pkg::*;

	logic [31:0] ctrl_q;
	dss_freq_t   reach_set_q;
	dss_freq_t   reach_band_q;
	dss_freq_t   upper_q;
	logic [6:0]  first_open_collector_output_sel_q;
	logic [6:0]  second_open_collector_output_sel_q;
	logic [7:0]  st_sel_q;
	logic [7:0]  in3_sel_q;
	logic [7:0]  in4_sel_q;

	logic        reach_q;
	logic        gate_q;
	logic        fwd_q;
	logic        rev_q;
	logic        ramp_q;
	logic        jog_q;
	logic        inj_q;
	logic        fjf_q;
	logic        fjr_q;
	logic        first_open_collector_output_q;
	logic        second_open_collector_output_q;

	dss_stby_e   mode;
	logic        prio_en;
	logic        panel_mode;
	logic        stop_alt;
	logic        term_op;
	logic        wr_en;
	logic        rd_en;
	logic        addr_ok;
	logic        data_bad;
	logic        reach_d;
	logic        st_free;
	logic        jog_d;
	logic        inj_d;
	logic        fjf_d;
	logic        fjr_d;
	logic        gate_d;
	logic        fwd_d;
	logic        rev_d;
	logic        ramp_d;
	logic [16:0] lo_edge;
	logic [16:0] hi_edge;

	// Function active: base code is positive logic, base+1 negative logic
	function automatic logic fn_hit(input logic [7:0] sel, input logic pin,
		input logic [7:0] base);
		fn_hit = ((sel == base) && pin) || ((sel == base + 8'h01) && !pin);
	endfunction : fn_hit

	// Any of the three inputs carrying a function, the standby pin only while st_en is set
	function automatic logic fn_any(input logic [7:0] base, input logic st_en,
		input logic [7:0] s_st, input logic p_st, input logic [7:0] s3, input logic p3,
		input logic [7:0] s4, input logic p4);
		fn_any = (st_en && fn_hit(s_st, p_st, base)) || fn_hit(s3, p3, base)
			|| fn_hit(s4, p4, base);
	endfunction : fn_any

	// Output terminal drive from its selection code
	function automatic logic out_map(input logic [6:0] sel, input logic reach);
		if (sel == `DSS_OSEL_REACH_A)
			out_map = reach;
		else if (sel == `DSS_OSEL_REACH_B)
			out_map = !reach;
		else
			out_map = 1'b0;
	endfunction : out_map

	assign mode       = dss_stby_e'(ctrl_q[`DSS_CTRL_MODE_LSB +: 2]);
	assign prio_en    = ctrl_q[`DSS_CTRL_PRIO_BIT];
	assign panel_mode = ctrl_q[`DSS_CTRL_PANEL_BIT];
	assign stop_alt   = ctrl_q[`DSS_CTRL_STOPALT_BIT];
	// Terminal operation whenever panel mode is off, or in panel mode by the switch bit the far side drives
	assign term_op    = !panel_mode || ctrl_q[`DSS_CTRL_TSW_BIT];

	// APB decode; the slave answers in the first access cycle, so read data is
	// captured in the setup cycle and already stands at the access edge
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite && addr_ok && !data_bad;
	assign rd_en  = psel && !penable && !pwrite;

	always_comb
	begin
		addr_ok  = 1'b1;
		data_bad = 1'b0;
		case (paddr)
			`DSS_CTRL_OFF:       data_bad = (pwdata[1:0] == 2'b11);
			`DSS_REACH_SET_OFF:  data_bad = (pwdata[15:0] > upper_q) || |pwdata[31:16];
			`DSS_REACH_BAND_OFF: data_bad = (pwdata[15:0] > upper_q) || |pwdata[31:16];
			`DSS_UPPER_OFF:      data_bad = |pwdata[31:16];
			`DSS_FIRST_OPEN_COLLECTOR_OUTPUT_SEL_OFF:   data_bad = (pwdata > {25'h0, `DSS_OSEL_MAX});
			`DSS_SECOND_OPEN_COLLECTOR_OUTPUT_SEL_OFF:   data_bad = (pwdata > {25'h0, `DSS_OSEL_MAX});
			`DSS_ST_SEL_OFF:     data_bad = (pwdata > {24'h0, `DSS_ISEL_MAX});
			`DSS_IN3_SEL_OFF:    data_bad = (pwdata > {24'h0, `DSS_ISEL_MAX});
			`DSS_IN4_SEL_OFF:    data_bad = (pwdata > {24'h0, `DSS_ISEL_MAX});
			`DSS_STATUS_OFF:     data_bad = 1'b0;
			default:             addr_ok  = 1'b0;
		endcase
	end

	// Out-of-range values are refused whole rather than clipped
	assign pslverr = psel && penable && (!addr_ok || (pwrite && data_bad));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q       <= `DSS_CTRL_RST;
			reach_set_q  <= `DSS_REACH_SET_RST;
			reach_band_q <= `DSS_REACH_BAND_RST;
			upper_q      <= `DSS_UPPER_RST;
			first_open_collector_output_sel_q   <= `DSS_OSEL_RST;
			second_open_collector_output_sel_q   <= `DSS_OSEL_RST;
			st_sel_q     <= `DSS_ISEL_RST;
			in3_sel_q    <= `DSS_ISEL_RST;
			in4_sel_q    <= `DSS_ISEL_RST;
		end
		else if (wr_en)
		begin
			case (paddr)
				`DSS_CTRL_OFF:       ctrl_q       <= {26'h0, pwdata[5:0]};
				`DSS_REACH_SET_OFF:  reach_set_q  <= pwdata[15:0];
				`DSS_REACH_BAND_OFF: reach_band_q <= pwdata[15:0];
				`DSS_UPPER_OFF:      upper_q      <= pwdata[15:0];
				`DSS_FIRST_OPEN_COLLECTOR_OUTPUT_SEL_OFF:   first_open_collector_output_sel_q   <= pwdata[6:0];
				`DSS_SECOND_OPEN_COLLECTOR_OUTPUT_SEL_OFF:   second_open_collector_output_sel_q   <= pwdata[6:0];
				`DSS_ST_SEL_OFF:     st_sel_q     <= pwdata[7:0];
				`DSS_IN3_SEL_OFF:    in3_sel_q    <= pwdata[7:0];
				`DSS_IN4_SEL_OFF:    in4_sel_q    <= pwdata[7:0];
				default:             ctrl_q       <= ctrl_q;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en)
		begin
			case (paddr)
				`DSS_CTRL_OFF:       prdata <= ctrl_q;
				`DSS_REACH_SET_OFF:  prdata <= {16'h0000, reach_set_q};
				`DSS_REACH_BAND_OFF: prdata <= {16'h0000, reach_band_q};
				`DSS_UPPER_OFF:      prdata <= {16'h0000, upper_q};
				`DSS_FIRST_OPEN_COLLECTOR_OUTPUT_SEL_OFF:   prdata <= {25'h0, first_open_collector_output_sel_q};
				`DSS_SECOND_OPEN_COLLECTOR_OUTPUT_SEL_OFF:   prdata <= {25'h0, second_open_collector_output_sel_q};
				`DSS_ST_SEL_OFF:     prdata <= {24'h0, st_sel_q};
				`DSS_IN3_SEL_OFF:    prdata <= {24'h0, in3_sel_q};
				`DSS_IN4_SEL_OFF:    prdata <= {24'h0, in4_sel_q};
				`DSS_STATUS_OFF:     prdata <= {21'h0, second_open_collector_output_q, first_open_collector_output_q, fjr_q, fjf_q, inj_q,
					jog_q, ramp_q, rev_q, fwd_q, gate_q, reach_q};
				default:             prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Band edges in 17 bits so the upper edge cannot wrap
	assign hi_edge = {1'b0, reach_set_q} + {1'b0, reach_band_q};
	assign lo_edge = (reach_band_q > reach_set_q) ? 17'h0_0000
		: {1'b0, reach_set_q} - {1'b0, reach_band_q};
	assign reach_d = ({1'b0, output_freq} >= lo_edge) && ({1'b0, output_freq} <= hi_edge);

	// The standby pin is a general input only in always-on mode
	assign st_free = (mode == DSS_STBY_ALWAYS_ON);

	always_comb
	begin
		jog_d = 1'b0;
		inj_d = 1'b0;
		fjf_d = 1'b0;
		fjr_d = 1'b0;
		if (term_op || prio_en)
		begin
			jog_d = fn_any(`DSS_FN_JOG, st_free, st_sel_q, standby_terminal, in3_sel_q,
				multi_input_three, in4_sel_q, multi_input_four);
			// Priority for these three is withdrawn under the alternate stop pattern
			if (term_op || !stop_alt)
			begin
				inj_d = fn_any(`DSS_FN_INJ, st_free, st_sel_q, standby_terminal,
					in3_sel_q, multi_input_three, in4_sel_q, multi_input_four);
				fjf_d = fn_any(`DSS_FN_FJOG_FWD, st_free, st_sel_q, standby_terminal,
					in3_sel_q, multi_input_three, in4_sel_q, multi_input_four);
				fjr_d = fn_any(`DSS_FN_FJOG_REV, st_free, st_sel_q, standby_terminal,
					in3_sel_q, multi_input_three, in4_sel_q, multi_input_four);
			end
		end
	end

	always_comb
	begin
		fwd_d = term_op ? fwd_terminal : panel_run_fwd;
		rev_d = term_op ? rev_terminal : panel_run_rev;
		if (fwd_d && rev_d)
		begin
			fwd_d = 1'b0;
			rev_d = 1'b0;
		end
		case (mode)
			DSS_STBY_STANDARD:  gate_d = standby_terminal;
			DSS_STBY_ALWAYS_ON: gate_d = 1'b1;
			DSS_STBY_INTERLOCK: gate_d = fwd_terminal || rev_terminal;
			default:            gate_d = 1'b0;
		endcase
		// Ramp stop only where gates stay on and no run is asked for
		ramp_d = (mode == DSS_STBY_ALWAYS_ON) && !(fwd_d || rev_d || jog_d || fjf_d || fjr_d);
		if (!gate_d)
		begin
			fwd_d = 1'b0;
			rev_d = 1'b0;
		end
	end

	// One register stage, refreshed every cycle with no hold-over
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reach_q <= 1'b0;
			gate_q  <= 1'b0;
			fwd_q   <= 1'b0;
			rev_q   <= 1'b0;
			ramp_q  <= 1'b0;
			jog_q   <= 1'b0;
			inj_q   <= 1'b0;
			fjf_q   <= 1'b0;
			fjr_q   <= 1'b0;
			first_open_collector_output_q  <= 1'b0;
			second_open_collector_output_q  <= 1'b0;
		end
		else
		begin
			reach_q <= reach_d;
			gate_q  <= gate_d;
			fwd_q   <= fwd_d;
			rev_q   <= rev_d;
			ramp_q  <= ramp_d;
			jog_q   <= jog_d && gate_d;
			inj_q   <= inj_d;
			fjf_q   <= fjf_d && gate_d;
			fjr_q   <= fjr_d && gate_d;
			first_open_collector_output_q  <= out_map(first_open_collector_output_sel_q, reach_d);
			second_open_collector_output_q  <= out_map(second_open_collector_output_sel_q, reach_d);
		end
	end

	assign first_open_collector_output  = first_open_collector_output_q;
	assign second_open_collector_output = second_open_collector_output_q;
	assign gate_enable    = gate_q;
	assign run_fwd        = fwd_q;
	assign run_rev        = rev_q;
	assign ramp_stop      = ramp_q;
	assign jog_cmd        = jog_q;
	assign inj_brake_cmd  = inj_q;
	assign forced_jog_fwd = fjf_q;
	assign forced_jog_rev = fjr_q;

	reach_window_a: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> (reach_q == (({1'b0, $past(output_freq)} + {1'b0, $past(reach_band_q)}
		>= {1'b0, $past(reach_set_q)}) && ({1'b0, $past(output_freq)}
		<= {1'b0, $past(reach_set_q)} + {1'b0, $past(reach_band_q)}))))
		else $error("arrival flag disagrees with band");

	out_polarity_a: assert property (@(posedge pclk) disable iff (!presetn)
		(second_open_collector_output_sel_q == `DSS_OSEL_REACH_B) ##1 (second_open_collector_output_sel_q == `DSS_OSEL_REACH_B)
		|-> (second_open_collector_output != reach_q))
		else $error("closed-polarity output not inverted");

	std_coast_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == DSS_STBY_STANDARD && !standby_terminal) |=> !gate_enable && !run_fwd)
		else $error("gate not off with standby open");

	always_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == DSS_STBY_ALWAYS_ON) |=> gate_enable)
		else $error("always-on mode lost standby");

	ramp_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		ramp_stop |-> gate_enable && !run_fwd && !run_rev)
		else $error("ramp stop without gates on");

	interlock_run_a: assert property (@(posedge pclk) disable iff (!presetn)
		(mode == DSS_STBY_INTERLOCK && !fwd_terminal && !rev_terminal)
		|=> !gate_enable ##0 !forced_jog_fwd)
		else $error("interlock did not coast");

	panel_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!term_op && !prio_en) |=> !jog_cmd && !inj_brake_cmd && !forced_jog_rev)
		else $error("terminal command passed without priority");

	prio_jog_a: assert property (@(posedge pclk) disable iff (!presetn)
		(prio_en && mode == DSS_STBY_STANDARD && standby_terminal
		&& in4_sel_q == `DSS_FN_JOG && multi_input_four) |=> jog_cmd)
		else $error("prioritised jog not issued");

	stop_alt_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!term_op && stop_alt) |=> !inj_brake_cmd && !forced_jog_fwd)
		else $error("priority kept under alternate stop");

endmodule : dss_select

// [inc/dss_regs.svh]
// Register offsets, field positions, reset values and codes of the drive select logic
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH

// Register byte offsets
`define DSS_CTRL_OFF        8'h00
`define DSS_REACH_SET_OFF   8'h04
`define DSS_REACH_BAND_OFF  8'h08
`define DSS_UPPER_OFF       8'h0C
`define DSS_FIRST_OPEN_COLLECTOR_OUTPUT_SEL_OFF    8'h10
`define DSS_SECOND_OPEN_COLLECTOR_OUTPUT_SEL_OFF    8'h14
`define DSS_ST_SEL_OFF      8'h18
`define DSS_IN3_SEL_OFF     8'h1C
`define DSS_IN4_SEL_OFF     8'h20
`define DSS_STATUS_OFF      8'h24

// Control register fields
`define DSS_CTRL_MODE_LSB   0
`define DSS_CTRL_PRIO_BIT   2
`define DSS_CTRL_PANEL_BIT  3
`define DSS_CTRL_STOPALT_BIT 4
`define DSS_CTRL_TSW_BIT    5

// Reset values, frequencies in 0.1 Hz units
`define DSS_CTRL_RST        32'h0000_0008
`define DSS_REACH_SET_RST   16'h0000
`define DSS_REACH_BAND_RST  16'h0019
`define DSS_UPPER_RST       16'h0258
`define DSS_OSEL_RST        7'h00
`define DSS_ISEL_RST        8'h00

// Selection code limits
`define DSS_OSEL_MAX        7'h77
`define DSS_ISEL_MAX        8'h87

// Output selection codes for speed arrival
`define DSS_OSEL_REACH_A    7'h08
`define DSS_OSEL_REACH_B    7'h09

// Input function base codes; base+1 is the inverted-logic twin
`define DSS_FN_JOG          8'h12
`define DSS_FN_INJ          8'h16
`define DSS_FN_FJOG_FWD     8'h32
`define DSS_FN_FJOG_REV     8'h34

`endif

// [inc/dss_pkg.sv]
// Types shared by the drive select logic
package dss_pkg;

	typedef enum logic [1:0] {
		DSS_STBY_STANDARD   = 2'b00,
		DSS_STBY_ALWAYS_ON  = 2'b01,
		DSS_STBY_INTERLOCK  = 2'b10,
		DSS_STBY_RSVD       = 2'b11
	} dss_stby_e;

	typedef logic [15:0] dss_freq_t;

endpackage : dss_pkg

// [bench/dss_contacts.sv]
// Contact switch bank on the terminal board, facing the drive select logic
module dss_contacts (
	// Clock
	input  logic       pclk,
	// Requested closures: standby, forward, reverse, input three, input four
	input  logic [4:0] want,
	// Contacts, high while closed to common
	output logic       standby_terminal,
	output logic       fwd_terminal,
	output logic       rev_terminal,
	output logic       multi_input_three,
	output logic       multi_input_four
);
	timeunit 1ns;
	timeprecision 1ns;
	// Relays of a controller move one tick after the command, never mid-cycle
	always_ff @(posedge pclk)
	begin
		{standby_terminal, fwd_terminal, rev_terminal, multi_input_three,
			multi_input_four} <= want;
	end
endmodule : dss_contacts

// [bench/dss_select_bench.sv]
// Self-checking bench of the drive select logic
`include "dss_regs.svh"
module dss_select_bench;
	import dss_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	dss_freq_t   output_freq;
	logic [4:0]  want;
	logic        st, fw, rv, i3, i4, o1, o2, gate, rfw, rrv, ramp, jog, inj, fjf, fjr;
	logic        pfw, prv;
	int          mismatches, checked, cyc;
	logic [7:0]  codes [4] = '{`DSS_FN_JOG, `DSS_FN_INJ, `DSS_FN_FJOG_FWD, `DSS_FN_FJOG_REV};

	dss_contacts PART (.pclk(pclk), .want(want), .standby_terminal(st), .fwd_terminal(fw),
		.rev_terminal(rv), .multi_input_three(i3), .multi_input_four(i4));
	dss_select DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .output_freq(output_freq), .panel_run_fwd(pfw),
		.panel_run_rev(prv), .standby_terminal(st), .fwd_terminal(fw), .rev_terminal(rv),
		.multi_input_three(i3), .multi_input_four(i4), .first_open_collector_output(o1),
		.second_open_collector_output(o2), .gate_enable(gate), .run_fwd(rfw), .run_rev(rrv),
		.ramp_stop(ramp), .jog_cmd(jog), .inj_brake_cmd(inj), .forced_jog_fwd(fjf),
		.forced_jog_rev(fjr));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task results;
		$display("Counts: %0d checked, %0d mismatches", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// Response and read data are taken at the edge where pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		er = pslverr;
		rd = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rchk(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd, x);
	endtask : rchk

	task wr(input logic [7:0] a, input logic [31:0] d, input logic x);
		apb(1'b1, a, d);
		chk(er, x);
	endtask : wr

	// Contact moves through the partner, then one edge for the registered outputs
	task ct(input logic [4:0] v);
		@(posedge pclk);
		want <= v;
		repeat (3) @(posedge pclk);
		#1;
	endtask : ct

	task fq(input dss_freq_t f, input logic x);
		@(posedge pclk);
		output_freq <= f;
		repeat (3) @(posedge pclk);
		#1 chk(o2, x);
	endtask : fq

	task t_regs;
		rchk(`DSS_CTRL_OFF, 32'h0000_0008);
		rchk(`DSS_REACH_BAND_OFF, 32'h0000_0019);
		rchk(8'h28, 32'h0000_0000);
		chk(er, 1'b1);
		wr(`DSS_IN3_SEL_OFF, 32'h0000_0088, 1'b1);
		wr(`DSS_IN3_SEL_OFF, 32'h0000_0087, 1'b0);
		rchk(`DSS_IN3_SEL_OFF, 32'h0000_0087);
		wr(`DSS_SECOND_OPEN_COLLECTOR_OUTPUT_SEL_OFF, 32'h0000_0078, 1'b1);
		wr(`DSS_REACH_BAND_OFF, 32'h0000_0259, 1'b1);
		$display("done regs");
	endtask : t_regs

	task t_reach;
		wr(`DSS_REACH_SET_OFF, 32'h0000_0064, 1'b0);
		wr(`DSS_SECOND_OPEN_COLLECTOR_OUTPUT_SEL_OFF, 32'h0000_0008, 1'b0);
		fq(16'h004A, 1'b0);
		fq(16'h004B, 1'b1);
		fq(16'h007D, 1'b1);
		fq(16'h007E, 1'b0);
		wr(`DSS_SECOND_OPEN_COLLECTOR_OUTPUT_SEL_OFF, 32'h0000_0009, 1'b0);
		wr(`DSS_FIRST_OPEN_COLLECTOR_OUTPUT_SEL_OFF, 32'h0000_0008, 1'b0);
		fq(16'h0064, 1'b0);
		chk(o1, 1'b1);
		$display("done reach");
	endtask : t_reach

	task t_stby;
		ct(5'b10000);
		chk(gate, 1'b1);
		ct(5'b00000);
		chk(gate, 1'b0);
		wr(`DSS_CTRL_OFF, 32'h0000_0009, 1'b0);
		ct(5'b00000);
		chk(gate, 1'b1);
		chk(ramp, 1'b1);
		wr(`DSS_CTRL_OFF, 32'h0000_000A, 1'b0);
		ct(5'b01000);
		chk(gate, 1'b1);
		ct(5'b00100);
		chk(gate, 1'b1);
		ct(5'b00000);
		chk(gate, 1'b0);
		wr(`DSS_ST_SEL_OFF, {24'h0, `DSS_FN_JOG}, 1'b0);
		wr(`DSS_CTRL_OFF, 32'h0000_0021, 1'b0);
		ct(5'b10000);
		chk(jog, 1'b1);
		$display("done standby");
	endtask : t_stby

	task t_prio;
		wr(`DSS_CTRL_OFF, 32'h0000_0008, 1'b0);
		wr(`DSS_IN4_SEL_OFF, {24'h0, `DSS_FN_JOG}, 1'b0);
		ct(5'b10001);
		chk(jog, 1'b0);
		wr(`DSS_CTRL_OFF, 32'h0000_0028, 1'b0);
		ct(5'b10001);
		chk(jog, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			wr(`DSS_CTRL_OFF, 32'h0000_000C, 1'b0);
			wr(`DSS_IN4_SEL_OFF, {24'h0, codes[i]}, 1'b0);
			ct(5'b10001);
			chk({jog, inj, fjf, fjr}, 4'h8 >> i);
			wr(`DSS_IN4_SEL_OFF, {24'h0, codes[i] + 8'h01}, 1'b0);
			ct(5'b10000);
			chk({jog, inj, fjf, fjr}, 4'h8 >> i);
			wr(`DSS_CTRL_OFF, 32'h0000_001C, 1'b0);
			ct(5'b10000);
			chk({jog, inj, fjf, fjr}, (i == 0) ? 4'h8 : 4'h0);
		end
		$display("done priority");
	endtask : t_prio

	task t_run;
		wr(`DSS_CTRL_OFF, 32'h0000_0008, 1'b0);
		pfw <= 1'b1;
		ct(5'b10100);
		chk({rfw, rrv}, 2'b10);
		@(posedge pclk);
		{pfw, prv} <= 2'b01;
		ct(5'b11000);
		chk({rfw, rrv}, 2'b01);
		wr(`DSS_CTRL_OFF, 32'h0000_0028, 1'b0);
		ct(5'b11000);
		chk({rfw, rrv}, 2'b10);
		ct(5'b00100);
		chk({rfw, rrv}, 2'b00);
		wr(`DSS_CTRL_OFF, 32'h0000_002A, 1'b0);
		ct(5'b01000);
		chk({rfw, rrv}, 2'b10);
		wr(`DSS_CTRL_OFF, 32'h0000_0029, 1'b0);
		ct(5'b01000);
		chk(ramp, 1'b0);
		$display("done run");
	endtask : t_run

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			mismatches++;
			results;
		end
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, output_freq, want, pfw, prv} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_reach;
		t_stby;
		t_prio;
		t_run;
		results;
	end
endmodule : dss_select_bench
